// ### rtl/dss_supervisor.sv
// dual supply reset supervisor: turns undervoltage flags and a manual
// request into a processor reset with a guaranteed hold time
// assumes comparator flags and the manual input are synchronous to clk
//
// Contract
// - reset asserts while the adjustable input is below the reference.
// - reset asserts while the supply is below its trip level.
// - each undervoltage flag has distinct entry and exit behaviour so noise does not chatter.
// - short undervoltage excursions are ignored by a glitch filter.
// - a low manual request asserts reset regardless of the monitors.
// - reset stays asserted for the hold time after the last cause clears.
// - a reset pulse of at least the hold time is produced at power-up.
// - the manual input is debounced to give one clean sequence.
// - the manual input idles high via a pull-up and is active low.
// - the open-drain variant only pulls low, otherwise releases.
// - the hold time is no shorter than 140 ms.
`include "dss_defines.svh"

module dss_supervisor #(
  parameter int unsigned HOLD_CYCLES     = `DSS_HOLD_CYCLES,
  parameter int unsigned GLITCH_CYCLES   = `DSS_GLITCH_CYCLES,
  parameter int unsigned DEBOUNCE_CYCLES = `DSS_DEBOUNCE_CYCLES,
  parameter logic [1:0]  OUT_MODE        = `DSS_OUT_LOW_PP
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic in_below_ref,
  input  wire logic vdd_below_trip,
  input  wire logic manual_reset_request_n,
  output logic      reset_out,
  output logic      reset_out_oe_n
);
  // ----------------------------------------------------------------
  // cause filtering
  // ----------------------------------------------------------------
  dss_cause_if causes ();

  // glitch filter on entry, short exit count: hysteresis in time
  dss_filter #(.ENTER_CYCLES(GLITCH_CYCLES), .EXIT_CYCLES(`DSS_HYST_CYCLES)) u_in_filt (
    .clk    (clk),
    .rst    (rst),
    .raw    (in_below_ref),
    .filt_q (causes.in_uv)
  );
  dss_filter #(.ENTER_CYCLES(GLITCH_CYCLES), .EXIT_CYCLES(`DSS_HYST_CYCLES)) u_vdd_filt (
    .clk    (clk),
    .rst    (rst),
    .raw    (vdd_below_trip),
    .filt_q (causes.vdd_uv)
  );

  // a bouncing switch settles before release counts; press is taken at once
  logic mr_low;
  assign mr_low = ~manual_reset_request_n;
  dss_filter #(.ENTER_CYCLES(1), .EXIT_CYCLES(DEBOUNCE_CYCLES)) u_mr_filt (
    .clk    (clk),
    .rst    (rst),
    .raw    (mr_low),
    .filt_q (causes.mr_act)
  );

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  dss_pkg::dss_state_t state_q;
  dss_pkg::dss_state_t state_d;
  logic [`DSS_CNT_W-1:0] cnt_q;
  logic [`DSS_CNT_W-1:0] cnt_d;
  logic                  any_cause;
  logic                  hold_done;
  logic                  assert_d;

  // raw manual low also counts so assertion is immediate
  assign any_cause = causes.in_uv | causes.vdd_uv | causes.mr_act | mr_low;
  assign hold_done = cnt_q >= `DSS_CNT_W'(HOLD_CYCLES - 1);

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    unique case (state_q)
      dss_pkg::DSS_ST_POR, dss_pkg::DSS_ST_HOLD: begin
        if (any_cause) begin
          state_d = dss_pkg::DSS_ST_HOLD;
          cnt_d   = '0;
        end else if (hold_done) begin
          state_d = dss_pkg::DSS_ST_RUN;
          cnt_d   = '0;
        end else begin
          cnt_d = cnt_q + `DSS_CNT_W'(1);
        end
      end
      dss_pkg::DSS_ST_RUN: begin
        if (any_cause) begin
          state_d = dss_pkg::DSS_ST_HOLD;
          cnt_d   = '0;
        end
      end
      default: begin
        state_d = dss_pkg::DSS_ST_POR;
        cnt_d   = '0;
      end
    endcase
  end

  assign assert_d = (state_d != dss_pkg::DSS_ST_RUN);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= dss_pkg::DSS_ST_POR;
      cnt_q   <= '0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  // ----------------------------------------------------------------
  // output variant
  // ----------------------------------------------------------------
  // open drain: pin level is low while enable (active low) is low
  logic out_d;
  logic oe_n_d;
  assign out_d  = (OUT_MODE == `DSS_OUT_HIGH_PP) ? assert_d : ~assert_d &
                  (OUT_MODE != `DSS_OUT_LOW_OD);
  assign oe_n_d = (OUT_MODE == `DSS_OUT_LOW_OD) ? ~assert_d : 1'b0;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reset_out      <= (OUT_MODE == `DSS_OUT_HIGH_PP);
      reset_out_oe_n <= 1'b0;
    end else begin
      reset_out      <= out_d;
      reset_out_oe_n <= oe_n_d;
    end
  end
endmodule // dss_supervisor

// ### rtl/dss_defines.svh
// constants for the dual supply reset supervisor
// assumes a 100 MHz clock; all counts are in clock cycles
`ifndef DSS_DEFINES_SVH
`define DSS_DEFINES_SVH

`define DSS_CLK_PERIOD_NS   10
`define DSS_HOLD_TIME_MS    140
`define DSS_HOLD_CYCLES     ((`DSS_HOLD_TIME_MS * 1000000) / `DSS_CLK_PERIOD_NS)
`define DSS_GLITCH_CYCLES   16
`define DSS_DEBOUNCE_CYCLES 1000
`define DSS_HYST_CYCLES     4
`define DSS_MR_MIN_NS       33
`define DSS_CNT_W           24

`define DSS_OUT_HIGH_PP     2'h0
`define DSS_OUT_LOW_PP      2'h1
`define DSS_OUT_LOW_OD      2'h2

`endif

// ### rtl/dss_pkg.sv
// types for the dual supply reset supervisor
// used by the top module's sequencer only; the filter modules do not use it
package dss_pkg;
  typedef enum logic [2:0] {
    DSS_ST_POR  = 3'b001,
    DSS_ST_HOLD = 3'b010,
    DSS_ST_RUN  = 3'b100
  } dss_state_t;
endpackage

// ### rtl/dss_cause_if.sv
// filtered reset causes passed from the filters to the sequencer
// assumes one clock domain
interface dss_cause_if;
  logic in_uv;
  logic vdd_uv;
  logic mr_act;
  modport filt (output in_uv, output vdd_uv, output mr_act);
  modport seq  (input in_uv, input vdd_uv, input mr_act);
endinterface

// ### rtl/dss_filter.sv
// ----------------------------------------------------------------
// persistence filter: output follows input after it stays stable
// ----------------------------------------------------------------
// input assumed synchronous; separate counts for entry and exit give hysteresis in time
module dss_filter #(
  parameter int unsigned ENTER_CYCLES = 16,
  parameter int unsigned EXIT_CYCLES  = 4
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic raw,
  output logic      filt_q
);
  localparam int unsigned CW = 24;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          differs;
  logic [CW-1:0] limit;

  assign differs = raw != filt_q;
  assign limit   = filt_q ? CW'(EXIT_CYCLES) : CW'(ENTER_CYCLES);
  assign cnt_d   = differs ? cnt_q + CW'(1) : '0;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q  <= '0;
      filt_q <= 1'b0;
    end else if (differs && cnt_d >= limit) begin
      cnt_q  <= '0;
      filt_q <= raw;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule // dss_filter

// ### testbench/dss_supervisor_properties.sv
// checker for the reset supervisor in active-low push-pull mode
// assumes counts handed on from the bound instance
module dss_supervisor_properties #(
  parameter int unsigned HOLD_CYCLES     = 20,
  parameter int unsigned DEBOUNCE_CYCLES = 5
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_below_ref,
  input wire logic vdd_below_trip,
  input wire logic manual_reset_request_n,
  input wire logic reset_out,
  input wire logic reset_out_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // quiet time since the last raw cause
  // ----------------------------------------
  logic [7:0] quiet_q;
  wire        quiet = manual_reset_request_n & !in_below_ref & !vdd_below_trip;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) quiet_q <= 8'h00;
    else if (!quiet) quiet_q <= 8'h00;
    else if (quiet_q != 8'hff) quiet_q <= quiet_q + 8'h01;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  mr_assert_a: assert property (!manual_reset_request_n |=> !reset_out)
    else $error("manual request did not assert reset");
  in_uv_a: assert property (in_below_ref [*8] ##1 in_below_ref [*8] |-> ##[1:2] !reset_out)
    else $error("input undervoltage missed");
  vdd_uv_a: assert property (vdd_below_trip [*8] ##1 vdd_below_trip [*8] |-> ##[1:2] !reset_out)
    else $error("supply undervoltage missed");
  glitch_pass_a: assert property (reset_out && quiet ##1 in_below_ref [*3] ##1 quiet
    |-> reset_out [*3])
    else $error("short excursion asserted reset");
  hold_min_a: assert property ($rose(reset_out) |-> quiet_q >= HOLD_CYCLES)
    else $error("reset released early");
  hold_max_a: assert property (quiet_q == HOLD_CYCLES + DEBOUNCE_CYCLES + 8 |-> reset_out)
    else $error("reset held too long");
  no_chatter_a: assert property ($fell(reset_out) |=> !reset_out [*8])
    else $error("reset output chattered");
  drive_on_a: assert property (reset_out_oe_n == 1'b0)
    else $error("push-pull output released");
  cover property ($fell(reset_out) && manual_reset_request_n);
  cover property ($rose(reset_out));
  cover property (!manual_reset_request_n && !reset_out);
endmodule // dss_supervisor_properties
bind dss_supervisor dss_supervisor_properties #(.HOLD_CYCLES(HOLD_CYCLES),
  .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) u_props (.clk(clk), .rst(rst),
  .in_below_ref(in_below_ref), .vdd_below_trip(vdd_below_trip),
  .manual_reset_request_n(manual_reset_request_n), .reset_out(reset_out),
  .reset_out_oe_n(reset_out_oe_n));

// ### testbench/dss_button.sv
// push-button on the manual input, with the internal pull-up
// open contacts read high, so the line never floats
module dss_button (
  input  wire logic press,
  output logic      mr_n
);
  timeunit 1ns;
  timeprecision 1ns;
  assign mr_n = press ? 1'b0 : 1'b1;
endmodule // dss_button

// ### testbench/dss_supervisor_tb.sv
// bench for the reset supervisor, short counts, active-low push-pull
// assumes inputs change on the falling edge
module dss_supervisor_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 1'b0, rst = 1'b1, press = 1'b0, mr_n, rst_o, oe_n;
  logic [1:0] uv = 2'h0;
  int         error_cnt = 0, comparisons = 0, n;
  always #5 clk = ~clk;
  dss_button u_btn (.press(press), .mr_n(mr_n));
  dss_supervisor #(.HOLD_CYCLES(20), .DEBOUNCE_CYCLES(5)) u_dut (.clk(clk), .rst(rst),
    .in_below_ref(uv[0]), .vdd_below_trip(uv[1]), .manual_reset_request_n(mr_n),
    .reset_out(rst_o), .reset_out_oe_n(oe_n));
  // ----------------------------------------
  // shared tasks and scenarios
  // ----------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // a bounded wait: a hang counts as a mismatch
  task automatic wait_out(input logic lvl, output int cnt);
    cnt = 0;
    while (rst_o !== lvl) begin
      @(negedge clk);
      cnt++;
      if (cnt > 200) begin
        error_cnt++;
        finish_test();
      end
    end
  endtask
  task automatic uv_test(input logic [1:0] m);
    uv = m;
    repeat (15) @(negedge clk);
    uv = 2'h0;
    repeat (3) @(negedge clk);
    check(rst_o, 1'b1);
    uv = m;
    repeat (3) @(negedge clk);
    uv = 2'h0;
    repeat (3) @(negedge clk);
    check(rst_o, 1'b1);
    uv = m;
    repeat (18) @(negedge clk);
    check(rst_o, 1'b0);
    repeat (5) begin
      uv = ~uv & m;
      @(negedge clk);
    end
    check(rst_o, 1'b0);
    uv = 2'h0;
    wait_out(1'b1, n);
    // 4 clear samples end the cause, the first already taken in the toggle loop; the hold count starts after the last
    check(n >= 23, 1'b1);
  endtask
  task automatic mr_test();
    press = 1'b1;
    repeat (4) @(negedge clk);
    press = 1'b0;
    check(rst_o, 1'b0);
    repeat (6) begin
      press = ~press;
      @(negedge clk);
    end
    wait_out(1'b1, n);
    check(n >= 24, 1'b1);
  endtask
  initial begin
    repeat (2) @(negedge clk);
    check(rst_o, 1'b0);
    rst = 1'b0;
    wait_out(1'b1, n);
    check(n >= 20, 1'b1);
    check(oe_n, 1'b0);
    uv_test(2'h1);
    uv_test(2'h2);
    mr_test();
    finish_test();
  end
endmodule // dss_supervisor_tb
